// ==== rtl/jfps_top.sv ====
// Test-port flash programming sequencer: scan registers, command decode and page transfer.
// Functional notes
// - Page dump chain is one page plus eight bits, 1032 bits long.
// - Dump chain uses an 8-bit shifter reloaded byte by byte from flash.
// - First eight dump shifts only load byte zero; host ignores those bits.
// - Dump data leaves LSB of word zero first, MSB of word 3F last.
// - Command 1a starts chip erase; 1b polls until the device reports done.
// - Command 2g writes the full page; 2h polls for completion.
// - Page fill chain is 1024 bits, 8-bit shifter moves bytes to buffer.
// - Device is held in reset while the reset scan bit is one, unlatched.
// - Programming enabled only while enable register equals unlock pattern; reset clears it.
`timescale 1ns/1ns
module jfps_top import jfps_pkg::*; #(
  parameter int unsigned WORD_ADDR_W = 14,
  parameter int unsigned FIFO_DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_en_o,
  output logic dev_reset_o,
  output logic prog_enabled_o,
  output logic erase_start_o,
  output logic page_write_o,
  output logic [WORD_ADDR_W-PAGE_WORD_BITS-1:0] page_addr_o,
  input wire logic flash_busy_i,
  output logic pb_valid_o,
  input wire logic pb_ready_i,
  output logic [BYTE_IDX_W-1:0] pb_index_o,
  output logic [7:0] pb_data_o,
  output logic rd_req_o,
  output logic [WORD_ADDR_W:0] rd_addr_o,
  input wire logic [7:0] rd_data_i
);
  localparam int unsigned PAGE_W = WORD_ADDR_W - PAGE_WORD_BITS;
  localparam int unsigned ENTRY_W = BYTE_IDX_W + 8;

  if (WORD_ADDR_W <= PAGE_WORD_BITS || WORD_ADDR_W > ADDR_REG_W) begin : g_bad_addr
    $error("jfps_top word address width must lie between 7 and 16.");
  end

  logic rst_meta_q;
  logic rst_n;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_d_q;
  logic tck_rise;
  logic tck_fall;
  jfps_tap_t tap_q;
  logic [IR_W-1:0] ir_q;
  logic [IR_W-1:0] ir_sr_q;
  logic rst_bit_q;
  logic [UNLOCK_W-1:0] unlock_sr_q;
  logic [UNLOCK_W-1:0] unlock_q;
  logic [CMD_W-1:0] cmd_sr_q;
  logic bypass_q;
  logic prog_en;
  logic wr_mode_q;
  logic rd_mode_q;
  logic [ADDR_REG_W-1:0] addr_q;
  logic [7:0] data_lo_q;
  logic [7:0] data_hi_q;
  logic [1:0] latch_cnt_q;
  logic write_pend_q;
  logic erase_q;
  logic page_write_q;
  logic [7:0] fill_sr_q;
  logic [BIT_CNT_W-1:0] fill_bit_q;
  logic [BYTE_IDX_W:0] fill_cnt_q;
  logic fill_pend_q;
  logic [ENTRY_W-1:0] fill_entry_q;
  logic [7:0] dump_sr_q;
  logic [7:0] dump_next_q;
  logic [BIT_CNT_W-1:0] dump_bit_q;
  logic [BYTE_IDX_W-1:0] dump_idx_q;
  logic rd_req_q;
  logic rd_ack_q;
  logic tdo_q;
  logic tdo_en_q;
  logic push_valid;
  logic push_ready;
  logic [ENTRY_W-1:0] push_entry;
  logic [ENTRY_W-1:0] pop_entry;
  logic shift_dr;
  logic upd_dr;
  logic cap_dr;
  logic [OP_W-1:0] opcode;

  function automatic jfps_tap_t tap_next(input jfps_tap_t s, input logic tms);
    case (s)
      JFPS_RESET: tap_next = tms ? JFPS_RESET : JFPS_IDLE;
      JFPS_IDLE: tap_next = tms ? JFPS_SEL_DR : JFPS_IDLE;
      JFPS_SEL_DR: tap_next = tms ? JFPS_SEL_IR : JFPS_CAP_DR;
      JFPS_CAP_DR: tap_next = tms ? JFPS_EXIT1_DR : JFPS_SHIFT_DR;
      JFPS_SHIFT_DR: tap_next = tms ? JFPS_EXIT1_DR : JFPS_SHIFT_DR;
      JFPS_EXIT1_DR: tap_next = tms ? JFPS_UPD_DR : JFPS_PAUSE_DR;
      JFPS_PAUSE_DR: tap_next = tms ? JFPS_EXIT2_DR : JFPS_PAUSE_DR;
      JFPS_EXIT2_DR: tap_next = tms ? JFPS_UPD_DR : JFPS_SHIFT_DR;
      JFPS_UPD_DR: tap_next = tms ? JFPS_SEL_DR : JFPS_IDLE;
      JFPS_SEL_IR: tap_next = tms ? JFPS_RESET : JFPS_CAP_IR;
      JFPS_CAP_IR: tap_next = tms ? JFPS_EXIT1_IR : JFPS_SHIFT_IR;
      JFPS_SHIFT_IR: tap_next = tms ? JFPS_EXIT1_IR : JFPS_SHIFT_IR;
      JFPS_EXIT1_IR: tap_next = tms ? JFPS_UPD_IR : JFPS_PAUSE_IR;
      JFPS_PAUSE_IR: tap_next = tms ? JFPS_EXIT2_IR : JFPS_PAUSE_IR;
      JFPS_EXIT2_IR: tap_next = tms ? JFPS_UPD_IR : JFPS_SHIFT_IR;
      JFPS_UPD_IR: tap_next = tms ? JFPS_SEL_DR : JFPS_IDLE;
      default: tap_next = JFPS_RESET;
    endcase
  endfunction

  // Reset is released through two flops; everything below uses the copy.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  jfps_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .async_i({tck_i, tms_i, tdi_i}),
    .sync_o({tck_s, tms_s, tdi_s})
  );

  // The test clock is oversampled, so its edges become single-cycle strobes.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tck_d_q <= 1'b0;
    end else begin
      tck_d_q <= tck_s;
    end
  end
  assign tck_rise = tck_s && !tck_d_q;
  assign tck_fall = !tck_s && tck_d_q;

  assign shift_dr = tck_rise && (tap_q == JFPS_SHIFT_DR);
  assign cap_dr = tck_rise && (tap_q == JFPS_CAP_DR);
  assign upd_dr = tck_rise && (tap_q == JFPS_UPD_DR);
  assign opcode = cmd_sr_q[OP_LSB +: OP_W];
  assign prog_en = (unlock_q == UNLOCK_PATTERN);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tap_q <= JFPS_RESET;
      ir_q <= IR_BYPASS;
      ir_sr_q <= '0;
    end else if (tck_rise) begin
      tap_q <= tap_next(tap_q, tms_s);
      case (tap_q)
        JFPS_RESET: ir_q <= IR_BYPASS;
        JFPS_CAP_IR: ir_sr_q <= IR_CAPTURE;
        JFPS_SHIFT_IR: ir_sr_q <= {tdi_s, ir_sr_q[IR_W-1:1]};
        JFPS_UPD_IR: ir_q <= ir_sr_q;
        default: ir_sr_q <= ir_sr_q;
      endcase
    end
  end

  // The reset bit drives the device reset straight from the shift stage, with no update latch.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rst_bit_q <= 1'b0;
      bypass_q <= 1'b0;
    end else if (shift_dr) begin
      if (ir_q == IR_HOLD_IN_RESET) begin
        rst_bit_q <= tdi_s;
      end
      bypass_q <= tdi_s;
    end
  end
  assign dev_reset_o = rst_bit_q;

  // A power-on reset clears the unlock register; a wrong pattern leaves programming off.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      unlock_sr_q <= UNLOCK_RESET;
      unlock_q <= UNLOCK_RESET;
    end else if (ir_q == IR_PROGRAM_UNLOCK) begin
      if (shift_dr) begin
        unlock_sr_q <= {tdi_s, unlock_sr_q[UNLOCK_W-1:1]};
      end else if (upd_dr) begin
        unlock_q <= unlock_sr_q;
      end
    end
  end
  assign prog_enabled_o = prog_en;

  // Command register: capture returns the completion flag, update executes.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_sr_q <= '0;
      wr_mode_q <= 1'b0;
      rd_mode_q <= 1'b0;
      addr_q <= '0;
      data_lo_q <= '0;
      data_hi_q <= '0;
      erase_q <= 1'b0;
    end else begin
      erase_q <= 1'b0;
      if (!prog_en) begin
        wr_mode_q <= 1'b0;
        rd_mode_q <= 1'b0;
      end
      if (ir_q == IR_COMMAND_SHIFT && cap_dr) begin
        cmd_sr_q <= CMD_W'({!flash_busy_i, DONE_BIT'(0)});
      end else if (ir_q == IR_COMMAND_SHIFT && shift_dr) begin
        cmd_sr_q <= {tdi_s, cmd_sr_q[CMD_W-1:1]};
      end else if (ir_q == IR_COMMAND_SHIFT && upd_dr && prog_en) begin
        case (opcode)
          OP_NOP: begin
            wr_mode_q <= 1'b0;
            rd_mode_q <= 1'b0;
          end
          OP_ERASE_START: erase_q <= 1'b1;
          OP_WRITE_ENABLE: wr_mode_q <= 1'b1;
          OP_READ_ENABLE: rd_mode_q <= 1'b1;
          OP_ADDR_HIGH: addr_q[15:8] <= cmd_sr_q[7:0];
          OP_ADDR_LOW: addr_q[7:0] <= cmd_sr_q[7:0];
          OP_DATA_LOW: data_lo_q <= cmd_sr_q[7:0];
          OP_DATA_HIGH: data_hi_q <= cmd_sr_q[7:0];
          default: cmd_sr_q <= cmd_sr_q;
        endcase
      end
    end
  end
  assign erase_start_o = erase_q;
  assign page_addr_o = addr_q[WORD_ADDR_W-1:PAGE_WORD_BITS];

  // Latching a word queues two bytes; a page write waits until the queue has drained.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      latch_cnt_q <= 2'h0;
      write_pend_q <= 1'b0;
      page_write_q <= 1'b0;
    end else begin
      page_write_q <= 1'b0;
      if (ir_q == IR_COMMAND_SHIFT && upd_dr && prog_en && wr_mode_q && opcode == OP_DATA_LATCH) begin
        latch_cnt_q <= 2'h2;
      end else if (!fill_pend_q && push_ready && latch_cnt_q != 2'h0) begin
        latch_cnt_q <= latch_cnt_q - 2'h1;
      end
      if (ir_q == IR_COMMAND_SHIFT && upd_dr && prog_en && wr_mode_q && opcode == OP_PAGE_WRITE) begin
        write_pend_q <= 1'b1;
      end else if (write_pend_q && !push_valid && !pb_valid_o) begin
        write_pend_q <= 1'b0;
        page_write_q <= 1'b1;
      end
    end
  end
  assign page_write_o = page_write_q;

  // Page fill: every eighth shift hands a finished byte to the queue.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      fill_sr_q <= '0;
      fill_bit_q <= '0;
      fill_cnt_q <= '0;
      fill_pend_q <= 1'b0;
      fill_entry_q <= '0;
    end else begin
      if (fill_pend_q && push_ready) begin
        fill_pend_q <= 1'b0;
      end
      if (ir_q == IR_PAGE_FILL && cap_dr) begin
        fill_bit_q <= '0;
        fill_cnt_q <= '0;
      end else if (ir_q == IR_PAGE_FILL && shift_dr && prog_en && wr_mode_q) begin
        fill_sr_q <= {tdi_s, fill_sr_q[7:1]};
        fill_bit_q <= fill_bit_q + 1'b1;
        if (fill_bit_q == LAST_BIT && fill_cnt_q < (BYTE_IDX_W + 1)'(PAGE_BYTES)) begin
          fill_entry_q <= {fill_cnt_q[BYTE_IDX_W-1:0], tdi_s, fill_sr_q[7:1]};
          fill_pend_q <= 1'b1;
          fill_cnt_q <= fill_cnt_q + 1'b1;
        end
      end
    end
  end

  // Scan bytes outrank latched words; the host never uses both flows at once.
  always_comb begin
    push_valid = fill_pend_q || (latch_cnt_q != 2'h0);
    if (fill_pend_q) begin
      push_entry = fill_entry_q;
    end else if (latch_cnt_q == 2'h2) begin
      push_entry = {addr_q[PAGE_WORD_BITS-1:0], 1'b0, data_lo_q};
    end else begin
      push_entry = {addr_q[PAGE_WORD_BITS-1:0], 1'b1, data_hi_q};
    end
  end

  jfps_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_entry),
    .out_valid_o(pb_valid_o),
    .out_ready_i(pb_ready_i),
    .out_data_o(pop_entry)
  );
  assign pb_index_o = pop_entry[ENTRY_W-1:8];
  assign pb_data_o = pop_entry[7:0];

  // Page dump: the next byte is prefetched so it is ready at every eighth shift.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      dump_sr_q <= '0;
      dump_next_q <= '0;
      dump_bit_q <= '0;
      dump_idx_q <= '0;
      rd_req_q <= 1'b0;
      rd_ack_q <= 1'b0;
    end else begin
      rd_req_q <= 1'b0;
      rd_ack_q <= rd_req_q;
      if (rd_ack_q) begin
        dump_next_q <= rd_data_i;
      end
      if (ir_q == IR_PAGE_DUMP && cap_dr && prog_en) begin
        dump_bit_q <= '0;
        dump_idx_q <= '0;
        rd_req_q <= 1'b1;
      end else if (ir_q == IR_PAGE_DUMP && shift_dr && prog_en) begin
        dump_bit_q <= dump_bit_q + 1'b1;
        if (dump_bit_q == LAST_BIT) begin
          dump_sr_q <= dump_next_q;
          dump_idx_q <= dump_idx_q + 1'b1;
          rd_req_q <= 1'b1;
        end else begin
          dump_sr_q <= {1'b0, dump_sr_q[7:1]};
        end
      end
    end
  end
  assign rd_req_o = rd_req_q;
  assign rd_addr_o = {addr_q[WORD_ADDR_W-1:PAGE_WORD_BITS], dump_idx_q};

  // The host samples the output on its rising edge, so it changes on the falling one.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tdo_q <= 1'b0;
      tdo_en_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_en_q <= (tap_q == JFPS_SHIFT_DR) || (tap_q == JFPS_SHIFT_IR);
      if (tap_q == JFPS_SHIFT_IR) begin
        tdo_q <= ir_sr_q[0];
      end else begin
        case (ir_q)
          IR_HOLD_IN_RESET: tdo_q <= rst_bit_q;
          IR_PROGRAM_UNLOCK: tdo_q <= unlock_sr_q[0];
          IR_COMMAND_SHIFT: tdo_q <= cmd_sr_q[0];
          IR_PAGE_FILL: tdo_q <= fill_sr_q[0];
          IR_PAGE_DUMP: tdo_q <= dump_sr_q[0];
          default: tdo_q <= bypass_q;
        endcase
      end
    end
  end
  assign tdo_o = tdo_q;
  assign tdo_en_o = tdo_en_q;
endmodule // jfps_top

// ==== shared/jfps_pkg.sv ====
// Constants shared by the test-port flash programming sequencer.
package jfps_pkg;
  // Test-port instruction register.
  localparam int unsigned IR_W = 4;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_HOLD_IN_RESET = 4'hc;
  localparam logic [IR_W-1:0] IR_PROGRAM_UNLOCK = 4'h4;
  localparam logic [IR_W-1:0] IR_COMMAND_SHIFT = 4'h5;
  localparam logic [IR_W-1:0] IR_PAGE_FILL = 4'h6;
  localparam logic [IR_W-1:0] IR_PAGE_DUMP = 4'h7;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;

  // Unlock register and its signature.
  localparam int unsigned UNLOCK_W = 16;
  localparam logic [UNLOCK_W-1:0] UNLOCK_PATTERN = 16'ha370;
  localparam logic [UNLOCK_W-1:0] UNLOCK_RESET = 16'h0000;

  // Programming command register: opcode in the top seven bits, data below.
  localparam int unsigned CMD_W = 15;
  localparam int unsigned OP_W = 7;
  localparam int unsigned OP_LSB = 8;
  localparam int unsigned DONE_BIT = 9;
  localparam logic [OP_W-1:0] OP_NOP = 7'h23;
  localparam logic [OP_W-1:0] OP_ERASE_START = 7'h31;
  localparam logic [OP_W-1:0] OP_ERASE_POLL = 7'h33;
  localparam logic [OP_W-1:0] OP_WRITE_ENABLE = 7'h24;
  localparam logic [OP_W-1:0] OP_READ_ENABLE = 7'h25;
  localparam logic [OP_W-1:0] OP_ADDR_HIGH = 7'h07;
  localparam logic [OP_W-1:0] OP_ADDR_LOW = 7'h03;
  localparam logic [OP_W-1:0] OP_DATA_LOW = 7'h13;
  localparam logic [OP_W-1:0] OP_DATA_HIGH = 7'h17;
  localparam logic [OP_W-1:0] OP_DATA_LATCH = 7'h37;
  localparam logic [OP_W-1:0] OP_PAGE_WRITE = 7'h35;
  localparam logic [OP_W-1:0] OP_WRITE_POLL = 7'h36;

  // Page geometry: 64 words of 16 bits, 128 bytes, 1024 fill bits, 1032 dump bits.
  localparam int unsigned PAGE_WORD_BITS = 6;
  localparam int unsigned BYTE_IDX_W = 7;
  localparam int unsigned PAGE_BYTES = 128;
  localparam int unsigned BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam int unsigned ADDR_REG_W = 16;

  typedef enum logic [3:0] {
    JFPS_RESET, JFPS_IDLE, JFPS_SEL_DR, JFPS_CAP_DR, JFPS_SHIFT_DR, JFPS_EXIT1_DR,
    JFPS_PAUSE_DR, JFPS_EXIT2_DR, JFPS_UPD_DR, JFPS_SEL_IR, JFPS_CAP_IR, JFPS_SHIFT_IR,
    JFPS_EXIT1_IR, JFPS_PAUSE_IR, JFPS_EXIT2_IR, JFPS_UPD_IR
  } jfps_tap_t;
endpackage

// ==== rtl/jfps_sync.sv ====
// Two-stage synchroniser for levels entering the system clock domain.
`timescale 1ns/1ns
module jfps_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The first stage feeds only the second one.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // jfps_sync

// ==== rtl/jfps_fifo.sv ====
// Byte FIFO between the scan side and the flash page buffer.
`timescale 1ns/1ns
module jfps_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PTR_W = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("jfps_fifo depth must be a power of two of at least two.");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0] count_q;
  logic push;
  logic pop;

  assign in_ready_o = (count_q != (PTR_W + 1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_ptr_q];

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // jfps_fifo

// ==== tb/jfps_monitor.sv ====
// Concurrent checks on the sequencer's top-level ports.
`timescale 1ns/1ns
module jfps_monitor import jfps_pkg::*; #(
  parameter int unsigned WORD_ADDR_W = 14
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic dev_reset_o,
  input wire logic prog_enabled_o,
  input wire logic erase_start_o,
  input wire logic page_write_o,
  input wire logic [WORD_ADDR_W-PAGE_WORD_BITS-1:0] page_addr_o,
  input wire logic pb_valid_o,
  input wire logic pb_ready_i,
  input wire logic [BYTE_IDX_W-1:0] pb_index_o,
  input wire logic [7:0] pb_data_o,
  input wire logic rd_req_o,
  input wire logic [WORD_ADDR_W:0] rd_addr_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Last byte index fetched; a dump either restarts at zero or moves to the next byte.
  logic [BYTE_IDX_W-1:0] last_idx_q;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_idx_q <= '1;
    end else if (rd_req_o) begin
      last_idx_q <= rd_addr_o[BYTE_IDX_W-1:0];
    end
  end
  reset_clear_a: assert property (disable iff (1'b0) !rst_n_i |-> !prog_enabled_o && !dev_reset_o && !pb_valid_o)
    else $error("outputs not cleared in reset");
  erase_pulse_a: assert property (erase_start_o |-> prog_enabled_o ##1 !erase_start_o)
    else $error("bad erase pulse");
  write_gate_a: assert property (page_write_o |-> prog_enabled_o && !pb_valid_o ##1 !page_write_o)
    else $error("bad page write pulse");
  read_pace_a: assert property (rd_req_o |=> !rd_req_o [*8])
    else $error("byte fetches too close");
  read_page_a: assert property (rd_req_o |-> prog_enabled_o && rd_addr_o[WORD_ADDR_W:BYTE_IDX_W] == page_addr_o)
    else $error("fetch outside page");
  read_order_a: assert property (rd_req_o |-> rd_addr_o[BYTE_IDX_W-1:0] == last_idx_q + 7'h01 || rd_addr_o[BYTE_IDX_W-1:0] == '0)
    else $error("fetch order wrong");
  pb_hold_a: assert property (pb_valid_o && !pb_ready_i |=> pb_valid_o && $stable(pb_data_o) && $stable(pb_index_o))
    else $error("buffer entry dropped");
  pb_lock_a: assert property ($rose(pb_valid_o) |-> prog_enabled_o)
    else $error("buffer entry while locked");
  erase_seen_c: cover property (erase_start_o);
  write_seen_c: cover property (page_write_o);
  stall_seen_c: cover property (pb_valid_o && !pb_ready_i);
endmodule // jfps_monitor
bind jfps_top jfps_monitor #(.WORD_ADDR_W(WORD_ADDR_W)) mon (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .dev_reset_o(dev_reset_o), .prog_enabled_o(prog_enabled_o), .erase_start_o(erase_start_o),
  .page_write_o(page_write_o), .page_addr_o(page_addr_o), .pb_valid_o(pb_valid_o), .pb_ready_i(pb_ready_i),
  .pb_index_o(pb_index_o), .pb_data_o(pb_data_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o));

// ==== tb/jfps_host.sv ====
// Test-port host model that shifts instruction and data registers.
`timescale 1ns/1ns
module jfps_host (
  input wire logic clock_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  logic bit_q;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // One 80 ns test clock; it stands low between frames, and unused data bits toggle.
  // Mode and data change together with the falling test clock, which keeps each half at ten clocks.
  task automatic step(input logic m, input logic d, output logic q);
    tms_o <= m;
    tdi_o <= d;
    repeat (10) @(posedge clock_i);
    q = tdo_i;
    tck_o <= 1'b1;
    repeat (10) @(posedge clock_i);
    tck_o <= 1'b0;
  endtask
  task automatic start();
    repeat (5) step(1'b1, ~tdi_o, bit_q);
    step(1'b0, ~tdi_o, bit_q);
  endtask
  // Shifts n bits LSB first from idle and back to idle.
  task automatic scan(input logic ir, input int n, input logic [1031:0] din, output logic [1031:0] dout);
    dout = '0;
    step(1'b1, ~tdi_o, bit_q);
    if (ir) step(1'b1, ~tdi_o, bit_q);
    step(1'b0, ~tdi_o, bit_q);
    step(1'b0, ~tdi_o, bit_q);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, ~tdi_o, bit_q);
    step(1'b0, ~tdi_o, bit_q);
  endtask
endmodule // jfps_host

// ==== tb/test_jtag_flash_program_sequencer.sv ====
// Self-checking bench for the test-port flash programming sequencer.
`timescale 1ns/1ns
module test_jtag_flash_program_sequencer import jfps_pkg::*;;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b1;
  logic busy = 1'b0;
  logic pb_rdy = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic tck, tms, tdi, tdo, tdo_en, dev_rst, prog_en, erase_go, page_go, pb_valid, rd_req;
  logic [7:0] page_addr, pb_data;
  logic [6:0] pb_index;
  logic [14:0] rd_addr;
  logic [1031:0] din, dout;
  logic [14:0] exp_q[$];
  int fails = 0;
  int checks_done = 0;
  int n_erase = 0;
  int n_write = 0;
  int n_rd = 0;
  int n_en = 0;
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  jfps_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_en_o(tdo_en), .dev_reset_o(dev_rst), .prog_enabled_o(prog_en), .erase_start_o(erase_go),
    .page_write_o(page_go), .page_addr_o(page_addr), .flash_busy_i(busy), .pb_valid_o(pb_valid),
    .pb_ready_i(pb_rdy), .pb_index_o(pb_index), .pb_data_o(pb_data), .rd_req_o(rd_req),
    .rd_addr_o(rd_addr), .rd_data_i(rd_data));
  jfps_host h (.clock_i(clock_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
  task automatic chk(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  // The buffer stalls every other cycle; flash data is only valid the cycle after a fetch.
  always @(posedge clock_i) begin
    pb_rdy <= ~pb_rdy;
    rd_data <= (rd_req === 1'b1) ? ({1'b1, rd_addr[6:0]} ^ 8'h3c) : ~rd_data;
    if (erase_go === 1'b1) n_erase++;
    if (page_go === 1'b1) n_write++;
    if (rd_req === 1'b1) n_rd++;
    if (tdo_en === 1'b1) n_en++;
    if (pb_valid === 1'b1 && pb_rdy === 1'b1) chk({pb_index, pb_data} === exp_q.pop_front(), "buffer byte");
  end
  task automatic ir(input logic [3:0] c);
    h.scan(1'b1, 4, 1032'(c), dout);
  endtask
  task automatic cmd(input logic [6:0] op, input logic [7:0] d);
    h.scan(1'b0, 15, 1032'({op, d}), dout);
  endtask
  task automatic t_locked();
    chk(prog_en === 1'b0 && dev_rst === 1'b0, "not clear after reset");
    ir(IR_COMMAND_SHIFT);
    cmd(OP_ERASE_START, 8'h00);
    ir(IR_PAGE_DUMP);
    h.scan(1'b0, 16, '0, dout);
    chk(n_erase === 0 && n_rd === 0, "locked device acted");
  endtask
  task automatic t_enter();
    ir(IR_HOLD_IN_RESET);
    h.scan(1'b0, 1, 1032'(1), dout);
    chk(dev_rst === 1'b1, "reset not held");
    ir(IR_PROGRAM_UNLOCK);
    h.scan(1'b0, 16, 1032'(16'ha371), dout);
    chk(prog_en === 1'b0, "wrong pattern unlocked");
    h.scan(1'b0, 16, 1032'(UNLOCK_PATTERN), dout);
    chk(prog_en === 1'b1, "unlock refused");
  endtask
  task automatic t_erase();
    ir(IR_COMMAND_SHIFT);
    busy <= 1'b1;
    cmd(OP_ERASE_START, 8'h00);
    chk(n_erase === 1, "erase not started");
    cmd(OP_ERASE_POLL, 8'h00);
    chk(dout[DONE_BIT] === 1'b0, "busy shown done");
    busy <= 1'b0;
    cmd(OP_ERASE_POLL, 8'h00);
    chk(dout[DONE_BIT] === 1'b1, "done not shown");
  endtask
  task automatic t_fill();
    cmd(OP_WRITE_ENABLE, 8'h00);
    cmd(OP_ADDR_HIGH, 8'h01);
    cmd(OP_ADDR_LOW, 8'h40);
    for (int n = 0; n < 128; n++) begin
      din[8*n +: 8] = 8'(n) ^ 8'ha5;
      exp_q.push_back({7'(n), 8'(n) ^ 8'ha5});
    end
    ir(IR_PAGE_FILL);
    h.scan(1'b0, 1024, din, dout);
    ir(IR_COMMAND_SHIFT);
    chk(exp_q.size() === 0, "page bytes missing");
    cmd(OP_PAGE_WRITE, 8'h00);
    chk(n_write === 1 && page_addr === 8'h05, "page write wrong");
    cmd(OP_WRITE_POLL, 8'h00);
    chk(dout[DONE_BIT] === 1'b1, "write done not shown");
    cmd(OP_ADDR_HIGH, 8'h00);
    cmd(OP_ADDR_LOW, 8'h83);
    exp_q.push_back({7'h06, 8'h5a});
    exp_q.push_back({7'h07, 8'hc3});
    cmd(OP_DATA_LOW, 8'h5a);
    cmd(OP_DATA_HIGH, 8'hc3);
    cmd(OP_DATA_LATCH, 8'h00);
    cmd(OP_PAGE_WRITE, 8'h00);
    chk(exp_q.size() === 0 && n_write === 2 && page_addr === 8'h02, "word fill wrong");
  endtask
  task automatic t_dump();
    int en0;
    ir(IR_PAGE_DUMP);
    en0 = n_en;
    h.scan(1'b0, 1032, '0, dout);
    for (int n = 0; n < 128; n++) chk(dout[8+8*n +: 8] === ({1'b1, 7'(n)} ^ 8'h3c), "dump byte");
    chk(n_en - en0 > 20000 && n_en - en0 < 21000 && tdo_en === 1'b0, "output enable span wrong");
  endtask
  task automatic t_leave();
    ir(IR_COMMAND_SHIFT);
    cmd(OP_NOP, 8'h00);
    ir(IR_PROGRAM_UNLOCK);
    h.scan(1'b0, 16, '0, dout);
    h.scan(1'b0, 16, '0, dout);
    chk(prog_en === 1'b0, "still unlocked");
    ir(IR_COMMAND_SHIFT);
    cmd(OP_PAGE_WRITE, 8'h00);
    chk(n_write === 2, "locked page write");
    ir(IR_HOLD_IN_RESET);
    h.scan(1'b0, 1, '0, dout);
    chk(dev_rst === 1'b0, "reset not released");
  endtask
  task automatic summarize();
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    // Reset falls after every process waits on it, so the asynchronous clear really happens.
    rst_n_i <= 1'b0;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    h.start();
    t_locked();
    t_enter();
    t_erase();
    t_fill();
    t_dump();
    t_leave();
    summarize();
  end
  // The whole run needs about 215 us of test clocks.
  initial begin
    #300000;
    fails++;
    summarize();
  end
endmodule // test_jtag_flash_program_sequencer
